// >>> common/qei_cfg.svh
// constants for the quadrature encoder interface block
// Overview of operation
// (RL1) phase mode: leading channel gives direction
// (RL2) clock/direction mode: step clock plus direction level
// (RL3) count first channel only or both channels
// (RL4) optional swap of channel inputs before decoding
// (RL5) index reloads counter only when selected
// (RL6) programmable maximum position bounds the counter
// (RL7) reverse index loads maximum position value
// (RL8) velocity timer accumulates pulses per period
// (RL9) running total and latched count both readable
// (RL10) velocity idle while velocity capture or module disabled
// (RL11) flags: index, timer, direction change, error
// (RL12) per-source mask gates interrupt output
// (RL13) phase mode: both channels changing together flags error
// (RL14) power-of-two predivider, latch and clear accumulator
// (RL15) direction keeps last detected movement
// (RL16) software position write loads the counter
// (RL17) disabled module holds position, counts nothing; velocity timer reloads period
// (RL18) write one clears only that flag
`ifndef QEI_CFG_SVH
`define QEI_CFG_SVH
`define QEI_ADDR_CTRL 12'h000
`define QEI_ADDR_STAT 12'h004
`define QEI_ADDR_POS 12'h008
`define QEI_ADDR_MAXPOS 12'h00C
`define QEI_ADDR_LOAD 12'h010
`define QEI_ADDR_TIME 12'h014
`define QEI_ADDR_COUNT 12'h018
`define QEI_ADDR_SPEED 12'h01C
`define QEI_ADDR_INTEN 12'h020
`define QEI_ADDR_RIS 12'h024
`define QEI_ADDR_ISC 12'h028
`define QEI_CTRL_EN 0
`define QEI_CTRL_SWAP 1
`define QEI_CTRL_SIGMODE 2
`define QEI_CTRL_CAPMODE 3
`define QEI_CTRL_RESMODE 4
`define QEI_CTRL_VELEN 5
`define QEI_CTRL_VELDIV_LO 6
`define QEI_CTRL_VELDIV_HI 8
`define QEI_INT_INDEX 0
`define QEI_INT_TIMER 1
`define QEI_INT_DIR 2
`define QEI_INT_ERROR 3
`define QEI_NUM_INT 4
`define QEI_CTRL_RESET 32'h0000_0000
`define QEI_MAXPOS_RESET 32'h0000_0000
`define QEI_LOAD_RESET 32'h0000_0000
`endif

// >>> common/qei_pkg.sv
// types shared by the quadrature encoder interface block
package qei_pkg;
  typedef enum logic [1:0] {
    QEI_MOVE_NONE = 2'b00,
    QEI_MOVE_FWD = 2'b01,
    QEI_MOVE_REV = 2'b10
  } qei_move_t;
endpackage : qei_pkg

// >>> verilog/qei_decoder.sv
// edge decoder for phase and clock/direction encoder inputs
`timescale 1ns/1ps
`include "qei_cfg.svh"
module qei_decoder (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic swap,
  input wire logic clk_dir_mode,
  input wire logic both_edges,
  input wire logic phase_input_first,
  input wire logic phase_input_second,
  input wire logic index_in,
  output qei_pkg::qei_move_t move,
  output logic index_edge,
  output logic phase_err
);
  logic a_r, b_r, i_r;
  logic a_nxt, b_nxt, i_nxt;
  logic a, b, da, db;
  always_comb
  begin
    a = swap ? phase_input_second : phase_input_first; // RL4
    b = swap ? phase_input_first : phase_input_second; // RL4
    a_nxt = a;
    b_nxt = b;
    i_nxt = index_in;
    da = a ^ a_r;
    db = b ^ b_r;
    move = qei_pkg::QEI_MOVE_NONE;
    index_edge = enable && index_in && !i_r;
    phase_err = 1'b0;
    if (enable)
    begin
      if (clk_dir_mode)
      begin
        // rising step edge, direction level: high means reverse
        if (a && !a_r) // RL2
          move = b ? qei_pkg::QEI_MOVE_REV : qei_pkg::QEI_MOVE_FWD;
      end
      else if (da && db)
        phase_err = 1'b1; // RL13
      else if (da)
        move = (a ^ b) ? qei_pkg::QEI_MOVE_FWD : qei_pkg::QEI_MOVE_REV; // RL1
      else if (db && both_edges) // RL3
        move = (a ^ b) ? qei_pkg::QEI_MOVE_REV : qei_pkg::QEI_MOVE_FWD; // RL1
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      a_r <= 1'b0;
      b_r <= 1'b0;
      i_r <= 1'b0;
    end
    else
    begin
      a_r <= a_nxt;
      b_r <= b_nxt;
      i_r <= i_nxt;
    end
  end
endmodule : qei_decoder

// >>> verilog/qei_velocity.sv
// velocity accumulator with period timer and power-of-two predivider
`timescale 1ns/1ps
`include "qei_cfg.svh"
module qei_velocity #(
  parameter int WIDTH = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic pulse,
  input wire logic [2:0] prediv,
  input wire logic [WIDTH-1:0] period,
  output logic [WIDTH-1:0] timer,
  output logic [WIDTH-1:0] count,
  output logic [WIDTH-1:0] speed,
  output logic expire
);
  logic [WIDTH-1:0] timer_r, timer_nxt, count_r, count_nxt, speed_r, speed_nxt;
  logic [6:0] div_r, div_nxt;
  logic [6:0] div_mask;
  logic tick;
  always_comb
  begin
    div_mask = 7'((8'h01 << prediv) - 8'h01);
    div_nxt = div_r;
    tick = 1'b0;
    if (run && pulse)
    begin
      // predivider counts raw pulses, passes one in 2^prediv
      if ((div_r & div_mask) == div_mask) // RL14
      begin
        tick = 1'b1;
        div_nxt = 7'h00;
      end
      else
        div_nxt = div_r + 7'h01;
    end
    timer_nxt = timer_r;
    count_nxt = count_r + WIDTH'(tick); // RL8
    speed_nxt = speed_r;
    expire = 1'b0;
    if (!run) // RL10
    begin
      timer_nxt = period;
      count_nxt = count_r;
      div_nxt = 7'h00;
    end
    else if (timer_r == '0)
    begin
      expire = 1'b1;
      timer_nxt = period; // RL8
      speed_nxt = count_r + WIDTH'(tick); // RL14
      count_nxt = '0; // RL14
    end
    else
      timer_nxt = timer_r - WIDTH'(1);
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer_r <= '0;
      count_r <= '0;
      speed_r <= '0;
      div_r <= 7'h00;
    end
    else
    begin
      timer_r <= timer_nxt;
      count_r <= count_nxt;
      speed_r <= speed_nxt;
      div_r <= div_nxt;
    end
  end
  assign timer = timer_r;
  assign count = count_r; // RL9
  assign speed = speed_r; // RL9
endmodule : qei_velocity

// >>> verilog/qei_top.sv
// quadrature encoder interface top: apb registers, position counter, events
`timescale 1ns/1ps
`include "qei_cfg.svh"
module qei_top #(
  parameter int WIDTH = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic phase_input_first,
  input wire logic phase_input_second,
  input wire logic index_in,
  output logic irq
);
  logic [31:0] ctrl_r, ctrl_nxt;
  logic [WIDTH-1:0] pos_r, pos_nxt, maxpos_r, maxpos_nxt, load_r, load_nxt;
  logic dir_r, dir_nxt;
  logic err_r, err_nxt;
  logic [`QEI_NUM_INT-1:0] inten_r, inten_nxt, ris_r, ris_nxt, ev;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt, irq_r, irq_nxt;
  qei_pkg::qei_move_t move;
  logic index_edge, phase_err, expire, vel_run, acc, wr, rd, hit;
  logic [WIDTH-1:0] vtimer, vcount, vspeed;

  qei_decoder i_qei_decoder (
    .pclk(pclk),
    .presetn(presetn),
    .enable(ctrl_r[`QEI_CTRL_EN]), // RL17
    .swap(ctrl_r[`QEI_CTRL_SWAP]),
    .clk_dir_mode(ctrl_r[`QEI_CTRL_SIGMODE]),
    .both_edges(ctrl_r[`QEI_CTRL_CAPMODE]),
    .phase_input_first(phase_input_first),
    .phase_input_second(phase_input_second),
    .index_in(index_in),
    .move(move),
    .index_edge(index_edge),
    .phase_err(phase_err)
  );

  assign vel_run = ctrl_r[`QEI_CTRL_EN] && ctrl_r[`QEI_CTRL_VELEN]; // RL10

  qei_velocity #(.WIDTH(WIDTH)) i_qei_velocity (
    .pclk(pclk),
    .presetn(presetn),
    .run(vel_run),
    .pulse(move != qei_pkg::QEI_MOVE_NONE), // RL3
    .prediv(ctrl_r[`QEI_CTRL_VELDIV_HI:`QEI_CTRL_VELDIV_LO]),
    .period(load_r),
    .timer(vtimer),
    .count(vcount),
    .speed(vspeed),
    .expire(expire)
  );

  // reads are captured on the taking edge; writes land on the edge that ends the pready cycle,
  // so no write takes effect before the bus has answered it
  assign acc = psel && penable && !pready_r;
  assign wr = psel && penable && pready_r && pwrite;
  assign rd = acc && !pwrite;

  always_comb
  begin
    ctrl_nxt = ctrl_r;
    maxpos_nxt = maxpos_r;
    load_nxt = load_r;
    inten_nxt = inten_r;
    pos_nxt = pos_r;
    dir_nxt = dir_r;
    err_nxt = err_r;
    ev = '0;
    // mapped words are the aligned offsets up to the clear register
    hit = (paddr <= `QEI_ADDR_ISC) && (paddr[1:0] == 2'b00);
    prdata_nxt = 32'h0000_0000;
    if (move == qei_pkg::QEI_MOVE_FWD)
      pos_nxt = (pos_r >= maxpos_r) ? '0 : pos_r + WIDTH'(1); // RL6
    else if (move == qei_pkg::QEI_MOVE_REV)
      pos_nxt = (pos_r == '0 || pos_r > maxpos_r) ? maxpos_r : pos_r - WIDTH'(1); // RL6
    if (move != qei_pkg::QEI_MOVE_NONE)
    begin
      dir_nxt = (move == qei_pkg::QEI_MOVE_REV); // RL15
      ev[`QEI_INT_DIR] = (dir_nxt != dir_r); // RL11
    end
    if (index_edge)
    begin
      ev[`QEI_INT_INDEX] = 1'b1; // RL11
      if (ctrl_r[`QEI_CTRL_RESMODE]) // RL5
        pos_nxt = dir_nxt ? maxpos_r : '0; // RL7
    end
    if (phase_err)
    begin
      err_nxt = 1'b1; // RL13
      ev[`QEI_INT_ERROR] = 1'b1; // RL11
    end
    ev[`QEI_INT_TIMER] = expire; // RL11
    // set wins over clear for every event flag
    ris_nxt = ris_r | ev; // RL11
    if (wr)
    begin
      case (paddr)
        `QEI_ADDR_CTRL: ctrl_nxt = pwdata;
        `QEI_ADDR_POS: pos_nxt = pwdata[WIDTH-1:0]; // RL16
        `QEI_ADDR_MAXPOS: maxpos_nxt = pwdata[WIDTH-1:0]; // RL6
        `QEI_ADDR_LOAD: load_nxt = pwdata[WIDTH-1:0];
        `QEI_ADDR_INTEN: inten_nxt = pwdata[`QEI_NUM_INT-1:0]; // RL12
        `QEI_ADDR_ISC:
        begin
          ris_nxt = (ris_r & ~pwdata[`QEI_NUM_INT-1:0]) | ev; // RL18
          if (pwdata[`QEI_INT_ERROR] && !phase_err)
            err_nxt = 1'b0;
        end
        `QEI_ADDR_STAT, `QEI_ADDR_TIME, `QEI_ADDR_COUNT, `QEI_ADDR_SPEED, `QEI_ADDR_RIS: hit = 1'b1;
        default: hit = 1'b0;
      endcase
    end
    else if (rd)
    begin
      case (paddr)
        `QEI_ADDR_CTRL: prdata_nxt = ctrl_r;
        `QEI_ADDR_STAT: prdata_nxt = {30'h0000_0000, dir_r, err_r};
        `QEI_ADDR_POS: prdata_nxt = 32'(pos_r);
        `QEI_ADDR_MAXPOS: prdata_nxt = 32'(maxpos_r);
        `QEI_ADDR_LOAD: prdata_nxt = 32'(load_r);
        `QEI_ADDR_TIME: prdata_nxt = 32'(vtimer);
        `QEI_ADDR_COUNT: prdata_nxt = 32'(vcount); // RL9
        `QEI_ADDR_SPEED: prdata_nxt = 32'(vspeed); // RL9
        `QEI_ADDR_INTEN: prdata_nxt = 32'(inten_r);
        `QEI_ADDR_RIS: prdata_nxt = 32'(ris_r);
        `QEI_ADDR_ISC: prdata_nxt = 32'(ris_r & inten_r);
        default: hit = 1'b0;
      endcase
    end
    pready_nxt = acc;
    pslverr_nxt = acc && !hit;
    irq_nxt = |(ris_nxt & inten_nxt); // RL12
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r <= `QEI_CTRL_RESET;
      maxpos_r <= `QEI_MAXPOS_RESET;
      load_r <= `QEI_LOAD_RESET;
      inten_r <= '0;
      ris_r <= '0;
      pos_r <= '0;
      dir_r <= 1'b0;
      err_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      irq_r <= 1'b0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      maxpos_r <= maxpos_nxt;
      load_r <= load_nxt;
      inten_r <= inten_nxt;
      ris_r <= ris_nxt;
      pos_r <= pos_nxt;
      dir_r <= dir_nxt;
      err_r <= err_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq = irq_r;
endmodule : qei_top

// >>> testbench/qei_monitor.sv
// bus and interrupt checker for the encoder interface top
`timescale 1ns/1ps
module qei_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [3:0] msk_r;
  logic [3:0] msk_nxt;
  sequence s_take;
    psel && penable && !pready;
  endsequence
  always_comb
    msk_nxt = (psel && penable && pready && pwrite && paddr == 12'h020) ? pwdata[3:0] : msk_r;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      msk_r <= 4'h0;
    else
      msk_r <= msk_nxt;
  property p_answer; s_take |=> pready; endproperty
  a_answer: assert property (p_answer) else $error("late ready");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("long ready");
  property p_slverr; pready |-> pslverr == (paddr > 12'h028 || paddr[1:0] != 2'b00); endproperty
  a_slverr: assert property (p_slverr) else $error("bad pslverr");
  property p_idle; !pready |-> prdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("stray prdata");
  property p_irqmask; irq |-> msk_r != 4'h0; endproperty
  a_irqmask: assert property (p_irqmask) else $error("irq while masked");
  property p_maskoff; s_take ##0 (pwrite && paddr == 12'h020 && pwdata[3:0] == 4'h0) |-> ##2 !irq; endproperty
  a_maskoff: assert property (p_maskoff) else $error("irq after mask");
  property p_maskrd; pready && !pwrite && paddr == 12'h020 |-> prdata[3:0] == msk_r; endproperty
  a_maskrd: assert property (p_maskrd) else $error("mask readback");
  property p_iscrd; pready && !pwrite && paddr == 12'h028 |-> (prdata[3:0] & ~msk_r) == 4'h0; endproperty
  a_iscrd: assert property (p_iscrd) else $error("unmasked status");
endmodule : qei_monitor
bind qei_top qei_monitor i_qei_monitor (.*);

// >>> testbench/qei_encoder_model.sv
// encoder partner: quadrature phases, step and direction, index pulse
`timescale 1ns/1ps
module qei_encoder_model (
  input wire logic pclk,
  output logic phase_input_first,
  output logic phase_input_second,
  output logic index_in
);
  initial
  begin
    phase_input_first = 1'b0;
    phase_input_second = 1'b0;
    index_in = 1'b0;
  end
  // hold keeps a level for extra cycles to mimic a slow encoder
  task automatic put(input logic a, input logic b, input logic i, input int hold);
    @(posedge pclk);
    phase_input_first <= a;
    phase_input_second <= b;
    index_in <= i;
    repeat (hold) @(posedge pclk);
  endtask : put
  // going forward the first channel leads by a quarter cycle
  task automatic quad(input logic fwd, input int n);
    repeat (n)
      put(phase_input_second ^ fwd, phase_input_first ^ ~fwd, 1'b0, 1);
  endtask : quad
endmodule : qei_encoder_model

// >>> testbench/quadrature_encoder_interface_tb.sv
// self-checking bench for the quadrature encoder interface
`timescale 1ns/1ps
module quadrature_encoder_interface_tb;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic phase_input_first;
  logic phase_input_second;
  logic index_in;
  logic irq;
  logic [31:0] q;
  int n_errors;
  int samples_checked;
  logic [1:0] cd [8] = '{2'b10, 2'b00, 2'b10, 2'b00, 2'b01, 2'b11, 2'b01, 2'b00};
  qei_top i_qei_top (.*);
  qei_encoder_model i_qei_encoder_model (.*);
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial
  begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    end_sim();
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rd
  task automatic mv(input logic f, input int n);
    i_qei_encoder_model.quad(f, n);
  endtask : mv
  task automatic ix;
    i_qei_encoder_model.put(phase_input_first, phase_input_second, 1'b1, 1);
    i_qei_encoder_model.put(phase_input_first, phase_input_second, 1'b0, 1);
  endtask : ix
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h000, 32'h0);
    rd(12'h00C, 32'h0);
    rd(12'h030, 32'h0);
    wr(12'h00C, 32'h64);
    wr(12'h000, 32'h1);
    mv(1'b1, 8);
    rd(12'h008, 32'h4);
    wr(12'h000, 32'h9);
    mv(1'b1, 4);
    rd(12'h008, 32'h8);
    mv(1'b0, 2);
    rd(12'h008, 32'h6);
    rd(12'h004, 32'h2);
    wr(12'h008, 32'h0);
    mv(1'b0, 1);
    rd(12'h008, 32'h64);
    mv(1'b1, 1);
    rd(12'h008, 32'h0);
    wr(12'h008, 32'h32);
    mv(1'b1, 2);
    rd(12'h008, 32'h34);
    $display("test count done");
    wr(12'h000, 32'hB);
    mv(1'b1, 4);
    rd(12'h008, 32'h30);
    wr(12'h000, 32'h0);
    mv(1'b1, 4);
    i_qei_encoder_model.put(1'b1, 1'b1, 1'b0, 1);
    i_qei_encoder_model.put(1'b0, 1'b0, 1'b0, 1);
    rd(12'h008, 32'h30);
    rd(12'h004, 32'h2);
    wr(12'h000, 32'h5);
    foreach (cd[i])
      i_qei_encoder_model.put(cd[i][1], cd[i][0], 1'b0, 2);
    rd(12'h008, 32'h31);
    wr(12'h000, 32'h9);
    ix();
    rd(12'h008, 32'h31);
    wr(12'h000, 32'h19);
    mv(1'b1, 1);
    ix();
    rd(12'h008, 32'h0);
    mv(1'b1, 3);
    mv(1'b0, 1);
    ix();
    rd(12'h008, 32'h64);
    $display("test modes done");
    wr(12'h028, 32'hF);
    wr(12'h020, 32'h8);
    i_qei_encoder_model.put(~phase_input_first, ~phase_input_second, 1'b0, 1);
    rd(12'h024, 32'h8);
    chk({31'h0, irq}, 32'h1);
    rd(12'h004, 32'h3);
    ix();
    rd(12'h028, 32'h8);
    wr(12'h028, 32'h8);
    rd(12'h024, 32'h1);
    chk({31'h0, irq}, 32'h0);
    mv(1'b1, 1);
    rd(12'h024, 32'h5);
    $display("test events done");
    wr(12'h028, 32'hF);
    wr(12'h010, 32'h3E7);
    wr(12'h000, 32'h60);
    mv(1'b1, 8);
    rd(12'h018, 32'h0);
    wr(12'h000, 32'h69);
    mv(1'b1, 8);
    rd(12'h018, 32'h4);
    wr(12'h020, 32'h2);
    while (irq !== 1'b1)
      @(posedge pclk);
    rd(12'h01C, 32'h4);
    rd(12'h018, 32'h0);
    wr(12'h020, 32'h0);
    rd(12'h028, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("test velocity done");
    end_sim();
  end
endmodule : quadrature_encoder_interface_tb
